// ==== verilog/adc_host_pkg.sv ====
// Constants and carriers for the serial converter host controller.
// Assumes a 250 MHz system clock; all times convert to cycles of it.
package adc_host_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_PS      = 4000;
	localparam int CONV_TIME_NS       = 5000;   // Conversion, high-rate mode
	localparam int QUIET_TIME_NS      = 250;    // Read end to next start edge
	localparam int START_PULSE_NS     = 40;     // Least start pulse width
	localparam int LONG_PULSE_NS      = 6000;   // Long start pulse, auto-sleep
	localparam int WAKE_CONV_NS       = 10000;  // Short pulse wake plus convert
	localparam int SCLK_HALF_NS       = 32;     // 16 MHz max -> 31.25 ns half
	localparam int CONV_CYC   = (CONV_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int QUIET_CYC  = (QUIET_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int PULSE_CYC  = (START_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int LONG_CYC   = (LONG_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int WAKE_CYC   = (WAKE_CONV_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int SCLK_HALF_CYC = (SCLK_HALF_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// ----------------------------------------------------------------
	// Frame
	// ----------------------------------------------------------------
	localparam int FRAME_BITS  = 16;
	localparam int RESULT_BITS = 14;

	typedef struct packed {
		logic        sleep_mode;                // Sample taken in auto-sleep mode
		logic [13:0] code;                      // Raw result, msb first on line
	} sample_t;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_PULSE = 3'b001,
		ST_CONV  = 3'b011,
		ST_READ  = 3'b010,
		ST_QUIET = 3'b110
	} host_state_t;

endpackage

// ==== verilog/pin_sync.sv ====
// Two-flop synchroniser for a bundle of level inputs.
// Assumes inputs are asynchronous to i_clk.
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             i_clk,    // Sampling clock
	input  wire logic             i_arst_n, // Async reset, low
	input  wire logic [WIDTH-1:0] i_d,      // Asynchronous levels
	output logic      [WIDTH-1:0] o_q       // Synchronised levels
);
	logic [WIDTH-1:0] meta_reg;

	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			meta_reg <= '0;
			o_q      <= '0;
		end
		else
		begin
			meta_reg <= i_d;
			o_q      <= meta_reg;
		end
	end
endmodule

// ==== verilog/sclk_gen.sv ====
// Serial clock generator: emits a given number of clock pulses, idle low.
// Flags each falling edge it makes for data sampling (mode 0 polarity, phase one).
`timescale 1ns/1ps
module sclk_gen #(
	parameter int HALF_CYC = 8
) (
	input  wire logic       i_clk,     // System clock
	input  wire logic       i_arst_n,  // Async reset, low
	input  wire logic       i_go,      // Start a burst, one-cycle pulse
	input  wire logic [4:0] i_pulses,  // Pulses in burst, 1..16
	output logic            o_sclk,    // Serial clock out
	output logic            o_fall,    // Pulse: falling edge made this cycle
	output logic            o_busy     // Burst in progress
);
	initial
	begin
		// The divider is eight bits wide
		if (HALF_CYC < 1 || HALF_CYC > 256)
			$error("HALF_CYC must be 1 to 256");
	end

	logic [7:0] div_reg;
	logic [4:0] left_reg;

	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			div_reg  <= 8'h00;
			left_reg <= 5'h00;
			o_sclk   <= 1'b0;
			o_fall   <= 1'b0;
			o_busy   <= 1'b0;
		end
		else
		begin
			o_fall <= 1'b0;
			if (!o_busy)
			begin
				if (i_go)
				begin
					o_busy   <= 1'b1;
					left_reg <= i_pulses;
					div_reg  <= 8'(HALF_CYC - 1);
				end
			end
			else if (div_reg != 8'h00)
				div_reg <= div_reg - 8'h01;
			else
			begin
				div_reg <= 8'(HALF_CYC - 1);
				if (!o_sclk)
					o_sclk <= 1'b1;
				else
				begin
					// Clock returns low after last pulse and stays there
					o_sclk   <= 1'b0;
					o_fall   <= 1'b1;
					left_reg <= left_reg - 5'h01;
					if (left_reg == 5'h01)
						o_busy <= 1'b0;
				end
			end
		end
	end
endmodule

// ==== verilog/adc_host.sv ====
// Host controller for a 14-bit serial sampling converter.
// Drives the start pin and serial clock; samples status and data pins.
//
// Summary of operation
// - One read is exactly 16 clocks
// - Read ends 250 ns before next start
// - Serial clock at most 16 MHz
// - Start level at conversion end picks mode
// - Auto-sleep pulse 40ns-2us or over 6us
// - Serial clock returns and stays low
// - Clock low from start until conversion ends
// - Read may pause between bytes
// - High-rate: may read 5 us after start
// - Host supplies every serial clock edge
// - Select output gates the serial clock
// - SPI polarity zero, phase one
`timescale 1ns/1ps
module adc_host #(
	parameter int CONV_CYC  = adc_host_pkg::CONV_CYC,
	parameter int WAKE_CYC  = adc_host_pkg::WAKE_CYC,
	parameter int LONG_CYC  = adc_host_pkg::LONG_CYC,
	parameter int HALF_CYC  = adc_host_pkg::SCLK_HALF_CYC,
	parameter int BYTE_READ = 0
) (
	input  wire logic         I_CLK_SYS,      // 250 MHz system clock
	input  wire logic         I_ARST_N,       // Async reset, low
	input  wire logic         I_REQ,          // Request one sample, pulse
	input  wire logic         I_SLEEP_MODE,   // 1: auto-sleep, 0: high-rate
	input  wire logic         I_LONG_PULSE,   // Auto-sleep: use long start pulse
	input  wire logic         I_USE_STATUS,   // High-rate: wait on status pin
	input  wire logic         I_BIPOLAR,      // Sign-extend result
	input  wire logic         I_CONV_STATUS,  // Pin: device converting
	input  wire logic         I_SERIAL_OUT_LINE, // Pin: serial data
	output logic              O_CONVERT_START_N, // Pin: start, active low
	output logic              O_SCLK,         // Pin: serial clock
	output logic              O_SELECT,       // Pin: clock gate select, high
	output logic              O_READY,        // Can take a request
	output logic              O_VALID,        // Result valid, one-cycle pulse
	output logic signed [15:0] O_RESULT,      // Result, extended to 16 bits
	output logic              O_FRAME_ERR     // Leading zeros not seen, pulse
);
	// ----------------------------------------------------------------
	// Parameter checks
	// ----------------------------------------------------------------
	initial
	begin
		// The sequencer timer is 16 bits wide; longer waits would wrap
		if (CONV_CYC < 1 || CONV_CYC > 65535)
			$error("adc_host: CONV_CYC out of range");
		if (WAKE_CYC < CONV_CYC || WAKE_CYC > 65535)
			$error("adc_host: WAKE_CYC out of range");
		if (LONG_CYC < 1 || LONG_CYC > 65535)
			$error("adc_host: LONG_CYC out of range");
		if (HALF_CYC < 1 || HALF_CYC > 256)
			$error("adc_host: HALF_CYC out of range");
		if (BYTE_READ != 0 && BYTE_READ != 1)
			$error("adc_host: BYTE_READ must be 0 or 1");
		// A timed read needs some wait left after the start pulse
		if (CONV_CYC <= adc_host_pkg::PULSE_CYC)
			$error("adc_host: CONV_CYC not above the start pulse");
	end

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [1:0] pins_sync;
	logic       status_s;
	logic       serial_out_line_s;

	pin_sync #(.WIDTH(2)) u_sync (
		.i_clk    (I_CLK_SYS),
		.i_arst_n (I_ARST_N),
		.i_d      ({I_CONV_STATUS, I_SERIAL_OUT_LINE}),
		.o_q      (pins_sync)
	);
	assign status_s = pins_sync[1];
	assign serial_out_line_s  = pins_sync[0];

	// ----------------------------------------------------------------
	// Serial clock generator
	// ----------------------------------------------------------------
	logic       sclk_go;
	logic [4:0] sclk_pulses;
	logic       sclk_fall;
	logic       sclk_busy;

	sclk_gen #(.HALF_CYC(HALF_CYC)) u_sclk (
		.i_clk    (I_CLK_SYS),
		.i_arst_n (I_ARST_N),
		.i_go     (sclk_go),
		.i_pulses (sclk_pulses),
		.o_sclk   (O_SCLK),
		.o_fall   (sclk_fall),
		.o_busy   (sclk_busy)
	);

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	adc_host_pkg::host_state_t state_reg;
	logic [15:0]                timer_reg;
	logic                       sleep_reg;
	logic                       long_reg;
	logic                       status_seen_reg;
	logic [4:0]                 bits_reg;
	logic [15:0]                shift_reg;
	logic                       burst_reg;

	// Pin sync delays the status edge by two cycles; timeouts cover that
	function automatic logic [15:0] to16(input int v);
		to16 = 16'(v);
	endfunction

	// Wait after the start pulse. A device left asleep by an earlier long
	// pulse also needs its wake time, so the status watchdog allows it;
	// the long auto-sleep pulse waits the bare conversion time, and the timed read without status that time less the start pulse.
	function automatic logic [15:0] conv_wait(input logic sleep,
	                                          input logic long_p,
	                                          input logic use_status);
		if (sleep && !long_p)
			conv_wait = to16(WAKE_CYC);
		else if (sleep)
			conv_wait = to16(CONV_CYC);
		else if (use_status)
			conv_wait = to16(WAKE_CYC);
		else
			conv_wait = to16(CONV_CYC - adc_host_pkg::PULSE_CYC);
	endfunction

	// Two leading zeros show the read stayed in step with the device
	function automatic logic lead_ok(input logic [15:0] frame);
		lead_ok = (frame[15:14] == 2'b00);
	endfunction

	// Bipolar ranges are two's complement, so the msb carries the sign
	function automatic logic [15:0] extend_code(input logic [13:0] code,
	                                            input logic        bipolar);
		extend_code = bipolar ? {{2{code[13]}}, code} : {2'b00, code};
	endfunction

	always_ff @(posedge I_CLK_SYS or negedge I_ARST_N)
	begin
		if (!I_ARST_N)
		begin
			state_reg       <= adc_host_pkg::ST_IDLE;
			timer_reg       <= 16'h0000;
			sleep_reg       <= 1'b0;
			long_reg        <= 1'b0;
			O_CONVERT_START_N <= 1'b1;
		end
		else
		begin
			if (timer_reg != 16'h0000)
				timer_reg <= timer_reg - 16'h0001;
			case (state_reg)
			adc_host_pkg::ST_IDLE:
				if (I_REQ)
				begin
					// Clock is already low here, so the device resets its counter
					O_CONVERT_START_N <= 1'b0;
					sleep_reg <= I_SLEEP_MODE;
					long_reg  <= I_LONG_PULSE;
					if (I_SLEEP_MODE && I_LONG_PULSE)
						timer_reg <= to16(LONG_CYC);
					else
						timer_reg <= to16(adc_host_pkg::PULSE_CYC);
					state_reg <= adc_host_pkg::ST_PULSE;
				end
			adc_host_pkg::ST_PULSE:
				// High-rate returns high before conversion ends; auto-sleep
				// short pulse also ends early, long one ends after 6 us
				if (timer_reg == 16'h0000)
				begin
					O_CONVERT_START_N <= 1'b1;
					timer_reg <= conv_wait(sleep_reg, long_reg, I_USE_STATUS);
					state_reg <= adc_host_pkg::ST_CONV;
				end
			adc_host_pkg::ST_CONV:
			begin
				// Wait status fall, or fixed time when status is not used
				if ((status_seen_reg && !status_s
				     && (sleep_reg || I_USE_STATUS))
				    || timer_reg == 16'h0000)
					state_reg <= adc_host_pkg::ST_READ;
			end
			adc_host_pkg::ST_READ:
				if (bits_reg == 5'd16 && !sclk_busy && !burst_reg)
				begin
					timer_reg <= to16(adc_host_pkg::QUIET_CYC);
					state_reg <= adc_host_pkg::ST_QUIET;
				end
			adc_host_pkg::ST_QUIET:
				if (timer_reg == 16'h0000)
					state_reg <= adc_host_pkg::ST_IDLE;
			default:
				state_reg <= adc_host_pkg::ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Read engine: sixteen pulses, whole or as two bytes
	// ----------------------------------------------------------------
	logic in_read;
	logic in_idle;

	assign in_read     = (state_reg == adc_host_pkg::ST_READ);
	assign in_idle     = (state_reg == adc_host_pkg::ST_IDLE);
	assign sclk_pulses = (BYTE_READ != 0) ? 5'd8 : 5'd16;
	// A fall still in flight has not been counted yet; without the last
	// term the generator would be restarted for a needless extra burst
	assign sclk_go     = in_read && !sclk_busy && !burst_reg
	                     && bits_reg != 5'd16
	                     && !sclk_fall;
	assign O_READY     = in_idle;

	always_ff @(posedge I_CLK_SYS or negedge I_ARST_N)
	begin
		if (!I_ARST_N)
		begin
			bits_reg  <= 5'h00;
			shift_reg <= 16'h0000;
			burst_reg <= 1'b0;
		end
		else
		begin
			burst_reg <= sclk_go;
			// Our count clears in idle; the device clears its own on the
			// start edge, which only ever leaves idle with the clock low
			if (in_idle)
				bits_reg <= 5'h00;
			// Sample at our falling edge; data stays valid across it, and
			// the two-flop delay is shorter than a half period
			else if (sclk_fall && bits_reg != 5'd16)
			begin
				shift_reg <= {shift_reg[14:0], serial_out_line_s};
				bits_reg  <= bits_reg + 5'h01;
			end
		end
	end

	// ----------------------------------------------------------------
	// Clock gate select
	// ----------------------------------------------------------------
	// Select follows the read state one cycle late, so a shared port never passes
	// a clock edge to this device outside it
	always_ff @(posedge I_CLK_SYS or negedge I_ARST_N)
	begin
		if (!I_ARST_N)
			O_SELECT <= 1'b0;
		else
			O_SELECT <= in_read;
	end

	// ----------------------------------------------------------------
	// Status watch
	// ----------------------------------------------------------------
	// Only a fall after status was seen high counts: a status that ended
	// during the start pulse must not pass for a finished conversion.
	// Cleared in idle so each conversion starts from a clean slate.
	always_ff @(posedge I_CLK_SYS or negedge I_ARST_N)
	begin
		if (!I_ARST_N)
			status_seen_reg <= 1'b0;
		else if (in_idle)
			status_seen_reg <= 1'b0;
		else if (state_reg == adc_host_pkg::ST_CONV && status_s)
			status_seen_reg <= 1'b1;
	end

	// ----------------------------------------------------------------
	// Result formatting
	// ----------------------------------------------------------------
	// The result holds between samples so a slow reader sees a stable word
	logic done_pulse;
	assign done_pulse = in_read && bits_reg == 5'd16 && !sclk_busy && !burst_reg;

	always_ff @(posedge I_CLK_SYS or negedge I_ARST_N)
	begin
		if (!I_ARST_N)
		begin
			O_VALID     <= 1'b0;
			O_RESULT    <= 16'sh0000;
			O_FRAME_ERR <= 1'b0;
		end
		else
		begin
			O_VALID     <= done_pulse;
			O_FRAME_ERR <= done_pulse && !lead_ok(shift_reg);
			if (done_pulse)
				O_RESULT <= extend_code(shift_reg[13:0], I_BIPOLAR);
		end
	end
endmodule

// ==== verification/adc_dev_model.sv ====
// Behavioural converter: start pin, status pin and 16-bit serial frame.
// Assumes the host makes every serial clock edge and the start pulse.
`timescale 1ns/1ps
module adc_dev_model #(
	parameter int CONV_NS = 120,
	parameter int WAKE_NS = 240
) (
	input  wire logic        i_start_n,  // Start, low
	input  wire logic        i_sclk,     // Serial clock
	input  wire logic [13:0] i_code,     // Next result
	input  wire logic        i_bad_lead, // Spoil lead bit
	output logic             o_status,   // Converting
	output logic             o_serial_out_line     // Serial data
);
	logic [15:0] out_reg;
	logic        asleep;
	int          cnt;

	initial
	begin
		{o_status, o_serial_out_line, asleep} = 3'h2;
		out_reg = 16'h0000;
	end

	always @(negedge i_start_n)
	begin
		if (!i_sclk)
			cnt = 0;
		o_status = 1'b1;
		#(asleep ? WAKE_NS : CONV_NS);
		out_reg = {i_bad_lead, 1'b0, i_code};
		asleep = !i_start_n;
		o_status = 1'b0;
	end

	// Reads are never gated by sleep
	always @(posedge i_sclk)
		if (cnt == 0)
			o_serial_out_line <= out_reg[15];

	// New bit 10 ns after the fall; a released line shows the inverse
	always @(negedge i_sclk)
	begin
		cnt = cnt + 1;
		#10;
		if (cnt >= 16)
		begin
			o_serial_out_line = ~o_serial_out_line;
			cnt = 0;
		end
		else
			o_serial_out_line = out_reg[15 - cnt];
	end
endmodule

// ==== verification/adc_host_chk.sv ====
// Pin protocol checker for the converter host.
// Assumes binding to adc_host; counts are system clock cycles.
`timescale 1ns/1ps
module adc_host_chk #(
	parameter int CONV_CYC = 1250
) (
	input wire logic I_CLK_SYS,         // Clock
	input wire logic I_ARST_N,          // Reset, low
	input wire logic I_SLEEP_MODE,      // Mode
	input wire logic I_USE_STATUS,      // Status wait
	input wire logic I_CONV_STATUS,     // Status pin
	input wire logic O_CONVERT_START_N, // Start pin
	input wire logic O_SCLK,            // Serial clock
	input wire logic O_SELECT,          // Clock gate
	input wire logic O_READY,           // Idle
	input wire logic O_VALID            // Result
);
	localparam int QUIET_MIN = 62;
	localparam int PULSE_MIN = 10;      // 40 ns of start low
	logic        sclk_d;
	logic        start_d;
	logic [10:0] quiet_cnt;
	logic [12:0] since_start;
	logic [4:0]  fall_cnt;
	logic [11:0] low_len;

	default clocking @(posedge I_CLK_SYS); endclocking
	default disable iff (!I_ARST_N);

	always_ff @(posedge I_CLK_SYS or negedge I_ARST_N)
		if (!I_ARST_N)
			{sclk_d, start_d} <= 2'h1;
		else
			{sclk_d, start_d} <= {O_SCLK, O_CONVERT_START_N};

	// Saturating except fall_cnt, which wraps: a gap longer than the counter is always long enough
	always_ff @(posedge I_CLK_SYS or negedge I_ARST_N)
		if (!I_ARST_N)
		begin
			quiet_cnt   <= '1;
			since_start <= '1;
			fall_cnt    <= '0;
			low_len     <= '0;
		end
		else
		begin
			quiet_cnt   <= (sclk_d && !O_SCLK) ? 11'h000 : quiet_cnt + {10'h000, ~&quiet_cnt};
			since_start <= (start_d && !O_CONVERT_START_N) ? 13'h0000
				: since_start + {12'h000, ~&since_start};
			fall_cnt    <= (start_d && !O_CONVERT_START_N) ? 5'h00
				: fall_cnt + {4'h0, sclk_d && !O_SCLK};
			low_len     <= O_CONVERT_START_N ? 12'h000 : low_len + {11'h000, ~&low_len};
		end

	chk_sclk_held_low: assert property (
		(!O_CONVERT_START_N || I_CONV_STATUS) |-> !O_SCLK)
		else $error("serial clock high during conversion");
	chk_select_gate: assert property (O_SCLK |-> O_SELECT)
		else $error("serial clock without select");
	chk_high_time: assert property ($rose(O_SCLK) |-> O_SCLK [*8] ##1 !O_SCLK)
		else $error("serial clock high time wrong");
	chk_low_time: assert property ($fell(O_SCLK) |-> !O_SCLK [*8])
		else $error("serial clock low time short");
	chk_pulse_width: assert property ($rose(O_CONVERT_START_N) |-> low_len >= PULSE_MIN)
		else $error("start pulse too short");
	chk_quiet_gap: assert property ($fell(O_CONVERT_START_N) |-> quiet_cnt >= QUIET_MIN)
		else $error("start too soon after read");
	chk_sixteen_falls: assert property (O_VALID |-> fall_cnt == 5'd16)
		else $error("read not sixteen clocks");
	chk_idle_low: assert property (O_READY |-> !O_SCLK && !O_SELECT)
		else $error("serial clock not idle low");
	chk_conv_wait: assert property (
		$rose(O_SCLK) && !I_SLEEP_MODE && !I_USE_STATUS |-> since_start >= CONV_CYC - 4)
		else $error("timed read before conversion time");

	cover property (O_VALID && I_SLEEP_MODE);
	cover property (O_VALID && !I_SLEEP_MODE && !I_USE_STATUS);
	cover property ($rose(O_SELECT));
endmodule

// ==== verification/adc_host_bench.sv ====
// Self-checking bench: host controller against the converter model.
// Assumes shortened conversion counts that the model answers within.
`timescale 1ns/1ps
module adc_host_bench;
	logic               clk_sys, arst_n, req, sleep_mode, long_pulse, use_status, bipolar;
	logic               bad_lead, conv_status, serial_out_line, start_n, sclk, sel, ready, valid, frame_err;
	logic        [13:0] code;
	logic signed [15:0] result;
	int                 fails, checks_done, cycles;

	always #2 clk_sys = ~clk_sys;

	adc_host #(
		.CONV_CYC (40),
		.WAKE_CYC (80),
		.LONG_CYC (40)
	) u_dut (
		.I_CLK_SYS         (clk_sys),
		.I_ARST_N          (arst_n),
		.I_REQ             (req),
		.I_SLEEP_MODE      (sleep_mode),
		.I_LONG_PULSE      (long_pulse),
		.I_USE_STATUS      (use_status),
		.I_BIPOLAR         (bipolar),
		.I_CONV_STATUS     (conv_status),
		.I_SERIAL_OUT_LINE (serial_out_line),
		.O_CONVERT_START_N (start_n),
		.O_SCLK            (sclk),
		.O_SELECT          (sel),
		.O_READY           (ready),
		.O_VALID           (valid),
		.O_RESULT          (result),
		.O_FRAME_ERR       (frame_err)
	);

	adc_dev_model u_dev (
		.i_start_n  (start_n),
		.i_sclk     (sclk),
		.i_code     (code),
		.i_bad_lead (bad_lead),
		.o_status   (conv_status),
		.o_serial_out_line    (serial_out_line)
	);

	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			fails++;
			end_of_test();
		end
	end

	task automatic end_of_test();
		if (fails == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp)
		begin
			fails++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask

	// Mode is {sleep, long pulse, use status, bipolar}; poke requests while busy
	task automatic sample(input logic [3:0] mode, input logic [13:0] c, input logic bad,
		input logic poke);
		int n;
		n = 0;
		{sleep_mode, long_pulse, use_status, bipolar} = mode;
		code = c;
		bad_lead = bad;
		req = 1'b1;
		@(posedge clk_sys);
		#1 req = 1'b0;
		repeat (5) @(posedge clk_sys);
		#1 check("ready", 16'h0000, {15'h0000, ready});
		req = poke;
		@(posedge clk_sys);
		#1 req = 1'b0;
		while (valid !== 1'b1 && n < 3000)
		begin
			@(posedge clk_sys);
			#1 n++;
		end
		check("valid", 16'h0001, {15'h0000, valid});
		check("result", bipolar ? {{2{c[13]}}, c} : {2'b00, c}, result);
		check("frame_err", {15'h0000, bad}, {15'h0000, frame_err});
		n = 0;
		repeat (100)
		begin
			@(posedge clk_sys);
			#1 n += int'(start_n === 1'b0);
		end
		check("restart", 16'h0000, n[15:0]);
	endtask

	task automatic test_reset();
		check("idle pins", 16'h0024, {10'h000, start_n, sclk, sel, ready, valid, frame_err});
		check("result", 16'h0000, result);
	endtask

	task automatic test_high_rate();
		sample(4'b0010, 14'h2a5c, 1'b0, 1'b1);
		sample(4'b0010, 14'h1555, 1'b0, 1'b0);
	endtask

	task automatic test_timed_read();
		sample(4'b0001, 14'h2001, 1'b0, 1'b0);
		sample(4'b0001, 14'h1fff, 1'b0, 1'b0);
	endtask

	task automatic test_auto_sleep();
		sample(4'b1111, 14'h0000, 1'b0, 1'b0);
		sample(4'b1010, 14'h3fff, 1'b0, 1'b0);
	endtask

	task automatic test_frame_check();
		sample(4'b0010, 14'h0123, 1'b1, 1'b0);
	endtask

	initial
	begin
		{clk_sys, arst_n, req, sleep_mode, long_pulse, use_status, bipolar, bad_lead} = 8'h00;
		code = 14'h0000;
		repeat (6) @(posedge clk_sys);
		#1 arst_n = 1'b1;
		test_reset();
		test_high_rate();
		test_timed_read();
		test_auto_sleep();
		test_frame_check();
		end_of_test();
	end
endmodule

bind adc_host adc_host_chk #(
	.CONV_CYC (CONV_CYC)
) u_chk (
	.I_CLK_SYS         (I_CLK_SYS),
	.I_ARST_N          (I_ARST_N),
	.I_SLEEP_MODE      (I_SLEEP_MODE),
	.I_USE_STATUS      (I_USE_STATUS),
	.I_CONV_STATUS     (I_CONV_STATUS),
	.O_CONVERT_START_N (O_CONVERT_START_N),
	.O_SCLK            (O_SCLK),
	.O_SELECT          (O_SELECT),
	.O_READY           (O_READY),
	.O_VALID           (O_VALID)
);
